/* core/sca_convert_ctrl.sv */
/*
 * digital control of a 16-bit sar converter: conversion sequencing,
 * low-power self-run, power gating, output coding and parallel readout,
 * plus an apb slave for mode control and status.
 * assumes all pins synchronous to core_clk_i; the analog core presents
 * its code on adc_raw_i (straight binary) by the last conversion cycle.
 */
// Contract
// - running conversion ignores starts and power-down
// - start independent of select and read-enable
// - low-power mode self-times acquisition, restarts conversion
// - no self-start in fast or standard mode
// - self-run may exceed low-power throughput slightly
// - low-power mode cuts power after each conversion
// - host interface stays active during acquisition
// - coding input picks twos complement or binary
// - data outputs driven only when both enables low
// - parallel interface when interface select low
// - serial signals share parallel data pins
// - result readable until next conversion ends
// - busy high during conversion, low when done
`timescale 1ns/1ps

module sca_convert_ctrl (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // conversion control pins
    input wire logic convert_start_n_i,
    input wire logic power_down_input_i,
    output logic busy_o,
    output logic power_low_o,
    // analog core
    input wire logic [sca_pkg::RES_W-1:0] adc_raw_i,
    // read interface pins
    input wire sca_pkg::sca_rd_if_t rd_if_i,
    output logic [sca_pkg::RES_W-1:0] data_o,
    output logic data_oe_o
);
    import sca_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [RES_W-1:0] code_out(input logic [RES_W-1:0] raw,
                                                  input logic straight);
        logic [RES_W-1:0] r;
        r = raw;
        if (!straight) begin
            r[MSB_POS] = ~raw[MSB_POS];
        end
        return r;
    endfunction

    function automatic logic apb_hit(input logic [7:0] a);
        return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_RESULT) || (a == OFS_COUNT);
    endfunction

    sca_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic cnv_n_q;
    logic [1:0] mode_q;
    logic [RES_W-1:0] result_q;
    logic [31:0] count_q;
    logic [RES_W-1:0] data_q;
    logic start_fall;
    logic lowpwr;
    logic conv_done;
    logic acq_done;
    logic apb_wr;
    sca_apb_req_t req;

    assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                   paddr: paddr_i, pwdata: pwdata_i};
    assign lowpwr = (mode_q == MODE_LOWPWR);
    assign start_fall = cnv_n_q && !convert_start_n_i;
    assign conv_done = (state_q == ST_CONV) && (cnt_q == CONV_LAST);
    assign acq_done = (state_q == ST_ACQ) && (cnt_q == ACQ_LAST);

    // ----------------------------------------
    // start edge detect
    // ----------------------------------------
    // reset high so a pin already low at release is taken as an edge
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cnv_n_q <= 1'b1;
        end else begin
            cnv_n_q <= convert_start_n_i;
        end
    end

    // ----------------------------------------
    // conversion sequencer
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_ZERO;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= CNT_ZERO;
                    if (start_fall && !power_down_input_i) begin
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    // no abort path: starts and power-down are looked at only on the last cycle, to pick self-run
                    if (conv_done) begin
                        cnt_q <= CNT_ZERO;
                        if (lowpwr && !convert_start_n_i && !power_down_input_i) begin
                            state_q <= ST_ACQ;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_ACQ: begin
                    if (convert_start_n_i || power_down_input_i || !lowpwr) begin
                        state_q <= ST_IDLE;
                        cnt_q <= CNT_ZERO;
                    end else if (acq_done) begin
                        state_q <= ST_CONV;
                        cnt_q <= CNT_ZERO;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q <= CNT_ZERO;
                end
            endcase
        end
    end

    assign busy_o = (state_q == ST_CONV);
    // conversion circuitry off outside the conversion phase in low-power mode
    assign power_low_o = (lowpwr && (state_q != ST_CONV)) || power_down_input_i && !busy_o;

    // ----------------------------------------
    // result capture
    // ----------------------------------------
    // updated only on the final conversion cycle, so reads mid-conversion get the old code
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            result_q <= '0;
            count_q <= '0;
        end else if (conv_done) begin
            result_q <= adc_raw_i;
            count_q <= count_q + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // parallel readout
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            data_q <= '0;
        end else begin
            data_q <= code_out(result_q, rd_if_i.output_coding_select);
        end
    end

    assign data_o = data_q;
    // serial mode reuses these pins, so the parallel drive backs off when selected
    assign data_oe_o = !rd_if_i.dev_sel_n && !rd_if_i.read_en_n
                       && !rd_if_i.interface_select;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign pready_o = 1'b1;
    assign pslverr_o = req.psel && req.penable && !apb_hit(req.paddr);
    assign apb_wr = req.psel && req.penable && req.pwrite && (req.paddr == OFS_CTRL);

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            mode_q <= MODE_RST;
        end else if (apb_wr) begin
            mode_q <= req.pwdata[MODE_LSB +: 2];
        end
    end

    always_comb begin
        prdata_o = '0;
        if (req.psel && !req.pwrite) begin
            case (req.paddr)
                OFS_CTRL: prdata_o[MODE_LSB +: 2] = mode_q;
                OFS_STATUS: begin
                    prdata_o[ST_BUSY_POS] = busy_o;
                    prdata_o[ST_PWRLOW_POS] = power_low_o;
                    prdata_o[ST_PD_POS] = power_down_input_i;
                    prdata_o[ST_ACQ_POS] = (state_q == ST_ACQ);
                end
                OFS_RESULT: prdata_o[RES_W-1:0] = code_out(result_q,
                                                  rd_if_i.output_coding_select);
                OFS_COUNT: prdata_o = count_q;
                default: prdata_o = '0;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_no_abort: assert property (
        (busy_o && cnt_q != CONV_LAST) |=> busy_o)
        else $error("conversion ended early");
    chk_start_fall: assert property (
        (state_q == ST_IDLE && start_fall && !power_down_input_i) |=> busy_o ##[14:14] busy_o)
        else $error("start edge did not begin a full conversion");
    chk_start_indep: assert property (
        (state_q == ST_IDLE && start_fall && !power_down_input_i && rd_if_i.dev_sel_n)
        |=> busy_o)
        else $error("start gated by read interface");
    chk_auto_restart: assert property (
        (acq_done && !convert_start_n_i && !power_down_input_i && lowpwr) |=> busy_o)
        else $error("self-run restart missing");
    chk_no_auto_fast: assert property (
        ($fell(busy_o) && !$past(lowpwr)) |-> state_q == ST_IDLE)
        else $error("self-start outside low-power mode");
    chk_power_gate: assert property (
        (lowpwr && !busy_o) |-> power_low_o)
        else $error("power not reduced after conversion");
    chk_oe_gate: assert property (
        data_oe_o == (!rd_if_i.dev_sel_n && !rd_if_i.read_en_n && !rd_if_i.interface_select))
        else $error("data drive enable wrong");
    chk_hold_prev: assert property (
        (busy_o && cnt_q != CONV_LAST) |=> $stable(result_q))
        else $error("result changed mid-conversion");
    chk_coding_out: assert property (
        1'b1 |=> data_o == code_out($past(result_q), $past(rd_if_i.output_coding_select)))
        else $error("output coding wrong");
    chk_busy_done: assert property (
        $fell(busy_o) |-> result_q == $past(adc_raw_i))
        else $error("busy fell without new result");

    // ----------------------------------------
    // sequencing and readout checks
    // ----------------------------------------
    chk_busy_rise_cnt: assert property (
        $rose(busy_o) |-> cnt_q == CNT_ZERO)
        else $error("conversion began with stale count");
    chk_busy_width: assert property (
        $rose(busy_o) |-> ##15 $fell(busy_o))
        else $error("busy width wrong");
    chk_pd_ignored: assert property (
        (busy_o && power_down_input_i && cnt_q != CONV_LAST) |=> busy_o)
        else $error("power-down aborted conversion");
    chk_start_in_busy: assert property (
        (busy_o && start_fall && cnt_q != CONV_LAST)
        |=> busy_o && (cnt_q == $past(cnt_q) + 1'b1))
        else $error("start edge disturbed running conversion");
    chk_acq_len: assert property (
        (state_q == ST_ACQ && cnt_q != ACQ_LAST && !convert_start_n_i
         && !power_down_input_i && lowpwr) |=> state_q == ST_ACQ)
        else $error("acquisition cut short");
    chk_acq_exit: assert property (
        (state_q == ST_ACQ && convert_start_n_i) |=> state_q == ST_IDLE)
        else $error("self-run kept going after start released");
    chk_restart_now: assert property (
        (acq_done && lowpwr && !convert_start_n_i && !power_down_input_i)
        |=> busy_o && cnt_q == CNT_ZERO)
        else $error("self-run restart delayed");
    chk_no_acq_std: assert property (
        (state_q == ST_ACQ && !lowpwr) |=> state_q == ST_IDLE)
        else $error("acquisition timing outside low-power mode");
    chk_conv_to_idle: assert property (
        (conv_done && !lowpwr) |=> state_q == ST_IDLE)
        else $error("self-start outside low-power mode");
    chk_power_full: assert property (
        busy_o |-> !power_low_o)
        else $error("power reduced during conversion");
    chk_low_after_pd: assert property (
        (power_down_input_i && !busy_o) |-> power_low_o)
        else $error("power-down did not reduce power");
    chk_host_live: assert property (
        (state_q == ST_ACQ && psel_i && !pwrite_i && paddr_i == OFS_STATUS)
        |-> prdata_o[ST_ACQ_POS])
        else $error("host interface dead in acquisition");
    chk_status_busy: assert property (
        (psel_i && !pwrite_i && paddr_i == OFS_STATUS) |-> prdata_o[ST_BUSY_POS] == busy_o)
        else $error("status busy bit wrong");
    chk_oe_off: assert property (
        (rd_if_i.dev_sel_n || rd_if_i.read_en_n) |-> !data_oe_o)
        else $error("bus driven while not selected");
    chk_oe_parallel: assert property (
        (!rd_if_i.dev_sel_n && !rd_if_i.read_en_n && !rd_if_i.interface_select)
        |-> data_oe_o)
        else $error("parallel bus not driven");
    chk_oe_serial: assert property (
        rd_if_i.interface_select |-> !data_oe_o)
        else $error("parallel drive while pins serve serial");
    chk_full_word: assert property (
        (data_oe_o && $stable(result_q) && $stable(rd_if_i.output_coding_select))
        |-> data_o == code_out(result_q, rd_if_i.output_coding_select))
        else $error("partial result on bus");
    chk_twos_msb: assert property (
        ($stable(result_q) && $stable(rd_if_i.output_coding_select)
         && !rd_if_i.output_coding_select)
        |-> data_o == {~result_q[MSB_POS], result_q[MSB_POS-1:0]})
        else $error("twos complement coding wrong");
    chk_straight: assert property (
        ($stable(result_q) && $stable(rd_if_i.output_coding_select)
         && rd_if_i.output_coding_select) |-> data_o == result_q)
        else $error("straight binary coding wrong");
    chk_count_step: assert property (
        conv_done |=> count_q == $past(count_q) + 32'h0000_0001)
        else $error("conversion count not advanced");
    chk_result_load: assert property (
        conv_done |=> result_q == $past(adc_raw_i))
        else $error("result not loaded at conversion end");
    chk_edge_needed: assert property (
        (state_q == ST_IDLE && !start_fall) |=> !busy_o)
        else $error("conversion began without start edge");
    chk_pd_idle_block: assert property (
        (state_q == ST_IDLE && power_down_input_i) |=> !busy_o)
        else $error("start taken during power-down");

    cov_self_run: cover property (acq_done ##1 busy_o);
    cov_acq_abort: cover property (state_q == ST_ACQ && convert_start_n_i);
    cov_read_in_conv: cover property (busy_o && data_oe_o);
    cov_pd_block: cover property (start_fall && power_down_input_i && state_q == ST_IDLE);
    cov_start_ignored: cover property (busy_o && start_fall);

endmodule

/* core/sca_pkg.sv */
/*
 * shared constants and types for the sar converter control block.
 * assumes a 10 MHz core clock and an apb master with 32-bit data.
 */
package sca_pkg;

    // ----------------------------------------
    // clock and conversion timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_TIME_NS = 1500;
    // self-run period = conversion + acquisition, a little under the low-power limit
    localparam int ACQ_TIME_NS = 700;
    localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQ_CYC = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
    localparam logic [CNT_W-1:0] ACQ_LAST = CNT_W'(ACQ_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

    // ----------------------------------------
    // result and modes
    // ----------------------------------------
    localparam int RES_W = 16;
    localparam int MSB_POS = RES_W - 1;
    localparam logic [1:0] MODE_FAST = 2'h0;
    localparam logic [1:0] MODE_STD = 2'h1;
    localparam logic [1:0] MODE_LOWPWR = 2'h2;
    localparam logic [1:0] MODE_RST = MODE_STD;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam int MODE_LSB = 0;
    localparam int ST_BUSY_POS = 0;
    localparam int ST_PWRLOW_POS = 1;
    localparam int ST_PD_POS = 2;
    localparam int ST_ACQ_POS = 3;

    typedef enum {
        ST_IDLE,
        ST_CONV,
        ST_ACQ
    } sca_state_t;

    // read-interface pins travel together
    typedef struct packed {
        logic dev_sel_n;
        logic read_en_n;
        logic interface_select;
        logic output_coding_select;
    } sca_rd_if_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } sca_apb_req_t;

endpackage

/* test/sar_adc_convert_parallel_readout_bench.sv */
/*
 * self-checking bench for the converter control block.
 * assumes the package timing constants and a zero-wait apb slave.
 */
`timescale 1ns/1ps

module sar_adc_convert_parallel_readout_bench;
    import sca_pkg::*;

    logic clk = 1'b0;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic start_n;
    logic pd;
    logic busy;
    logic power_low;
    logic [RES_W-1:0] adc_raw;
    sca_rd_if_t rd_if;
    logic [RES_W-1:0] data;
    logic data_oe;
    int err_total = 0;
    int check_count = 0;

    always #50 clk = ~clk;

    sca_convert_ctrl u_sca_convert_ctrl (.core_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .convert_start_n_i(start_n), .power_down_input_i(pd), .busy_o(busy),
        .power_low_o(power_low), .adc_raw_i(adc_raw), .rd_if_i(rd_if), .data_o(data),
        .data_oe_o(data_oe));

    sca_host_model u_sca_host_model (.core_clk_i(clk), .data_i(data), .data_oe_i(data_oe),
        .convert_start_n_o(start_n), .rd_if_o(rd_if));

    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) err_total++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic apb_wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b1, addr, wd, rd, err);
    endtask

    task automatic apb_rd(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b0, addr, 32'h0, rd, err);
        cmp_word(rd, exp, "apb read data");
        cmp_bit(err, exp_err, "apb error flag");
    endtask

    // edges until busy shows lvl, capped so a stuck design cannot hang us
    task automatic wait_busy(input logic lvl, input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== lvl && n < lim);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(100 * 5000);
        err_total++;
        tally_and_finish();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        int n;
        logic [RES_W-1:0] v;
        rst_n <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        pd <= 1'b0;
        adc_raw <= 16'h1234;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cmp_bit(busy, 1'b0, "busy after reset");
        apb_rd(OFS_CTRL, {30'h0, MODE_RST}, 1'b0);
        $display("test reset done");
        // start with the read pins idle, then disturb it mid-conversion
        u_sca_host_model.set_start(1'b0);
        wait_busy(1'b1, 5, n);
        cmp_bit(busy, 1'b1, "busy after start");
        u_sca_host_model.set_start(1'b1);
        repeat (3) @(posedge clk);
        u_sca_host_model.set_start(1'b0);
        pd <= 1'b1;
        @(posedge clk);
        u_sca_host_model.set_start(1'b1);
        wait_busy(1'b0, 40, n);
        cmp_word(32'(n), 32'(CONV_CYC - 4), "busy width");
        pd <= 1'b0;
        wait_busy(1'b1, 20, n);
        cmp_bit(busy, 1'b0, "no extra conversion");
        u_sca_host_model.read_bus(2, v);
        cmp_word({16'h0, v}, 32'h1234, "binary result");
        u_sca_host_model.set_rd(1'b1, 1'b1, 1'b0, 1'b0);
        repeat (2) @(posedge clk);
        u_sca_host_model.read_bus(1, v);
        cmp_word({16'h0, v}, 32'h1234 ^ 32'h8000, "twos complement result");
        for (int i = 0; i < 3; i++) begin
            u_sca_host_model.set_rd(i == 0, i == 1, i == 2, 1'b1);
            @(posedge clk);
            cmp_bit(data_oe, 1'b0, "bus released");
        end
        $display("test single conversion done");
        adc_raw <= 16'hABCD;
        u_sca_host_model.set_start(1'b0);
        wait_busy(1'b1, 5, n);
        u_sca_host_model.set_start(1'b1);
        u_sca_host_model.read_bus(2, v);
        cmp_word({16'h0, v}, 32'h1234, "previous result");
        wait_busy(1'b0, 40, n);
        repeat (2) @(posedge clk);
        u_sca_host_model.read_bus(1, v);
        cmp_word({16'h0, v}, 32'hABCD, "new result");
        $display("test read during conversion done");
        for (int m = 0; m < 2; m++) begin
            apb_wr(OFS_CTRL, {30'h0, (m == 0) ? MODE_FAST : MODE_STD});
            u_sca_host_model.set_start(1'b0);
            wait_busy(1'b1, 5, n);
            wait_busy(1'b0, 40, n);
            wait_busy(1'b1, 30, n);
            cmp_bit(busy, 1'b0, "no self start");
            u_sca_host_model.set_start(1'b1);
            @(posedge clk);
        end
        $display("test no self start done");
        apb_wr(OFS_CTRL, {30'h0, MODE_LOWPWR});
        u_sca_host_model.set_start(1'b0);
        wait_busy(1'b1, 5, n);
        wait_busy(1'b0, 40, n);
        apb_rd(OFS_STATUS, 32'h0000000A, 1'b0);
        cmp_bit(power_low, 1'b1, "power low in acquisition");
        wait_busy(1'b1, 10, n);
        wait_busy(1'b0, 40, n);
        cmp_word(32'(n), 32'(CONV_CYC), "self-run conversion");
        wait_busy(1'b1, 20, n);
        cmp_word(32'(n), 32'(ACQ_CYC), "self-run acquisition");
        cmp_bit((CONV_CYC + ACQ_CYC) * CLK_PERIOD_NS < 2253, 1'b1, "self-run period");
        u_sca_host_model.set_start(1'b1);
        wait_busy(1'b0, 40, n);
        wait_busy(1'b1, 30, n);
        cmp_bit(busy, 1'b0, "self-run stops");
        $display("test low power self run done");
        apb_rd(OFS_RESULT, 32'h0000ABCD, 1'b0);
        apb_rd(OFS_COUNT, 32'h00000007, 1'b0);
        apb_rd(8'h10, 32'h0, 1'b1);
        $display("test unmapped access done");
        tally_and_finish();
    end
endmodule

/* test/sca_host_model.sv */
/*
 * host-side model: drives convert start and the read pins, watches the data bus.
 * assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps

module sca_host_model (
    // clock
    input wire logic core_clk_i,
    // device data bus
    input wire logic [sca_pkg::RES_W-1:0] data_i,
    input wire logic data_oe_i,
    // device control pins
    output logic convert_start_n_o,
    output sca_pkg::sca_rd_if_t rd_if_o
);
    import sca_pkg::*;

    logic [RES_W-1:0] bus_last_q = '0;
    logic [RES_W-1:0] bus_w;

    // no pull on the lines: a released bus shows a pattern that keeps changing
    assign bus_w = data_oe_i ? data_i : ~bus_last_q;

    always_ff @(posedge core_clk_i) begin
        bus_last_q <= bus_w;
    end

    initial begin
        convert_start_n_o = 1'b1;
        rd_if_o = 4'hD;
    end

    task automatic set_start(input logic lvl);
        convert_start_n_o <= lvl;
    endtask

    task automatic set_rd(input logic sel_n, input logic rd_n, input logic ifs, input logic obc);
        rd_if_o <= {sel_n, rd_n, ifs, obc};
    endtask

    // waitc makes the host slow or prompt; keep it short inside a conversion
    task automatic read_bus(input int waitc, output logic [RES_W-1:0] val);
        set_rd(1'b0, 1'b0, 1'b0, rd_if_o.output_coding_select);
        repeat (waitc) @(posedge core_clk_i);
        val = bus_w;
        rd_if_o.read_en_n <= 1'b1;
        // let the release settle so a following call never drives the pins in the same step
        @(posedge core_clk_i);
    endtask
endmodule
